//--- csel_top.v
// Clock source selection and internal high-frequency oscillator control
`default_nettype none
`include "csel_defines.vh"

module csel_top (
    input wire clk,
    input wire reset_n,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata_ff,
    input wire [6:0] factory_trim,
    input wire hf_osc_clk,
    input wire ext_osc_clk,
    input wire lf_osc_clk,
    input wire [1:0] lf_osc_post_divide,
    input wire wake_port0_match,
    input wire wake_port1_match,
    input wire wake_timer3_ovf,
    input wire wake_usb_resume,
    output reg [6:0] hf_osc_trim_ff,
    output wire hf_osc_run,
    output wire core_clock_run,
    output wire core_clock,
    output wire usb_clock,
    output reg pin_clock_ff
);

    // Control state
    reg [2:0] core_clock_source_sel_ff;
    reg [2:0] usb_clk_source_sel_ff;
    reg pin_clock_sync_sel_ff;
    reg hf_osc_enable_ff;
    reg hf_osc_suspend_ff;
    reg [1:0] hf_osc_post_divide_ff;
    reg nxt_suspend;

    // Source synchronisers and edge history
    reg [2:0] src_meta_ff;
    reg [2:0] src_sync_ff;
    reg [2:0] src_prev_ff;

    // Dividers, HF settle timer and pin clock sync
    reg [4:0] hf_cnt_ff;
    reg [1:0] ext_cnt_ff;
    reg [1:0] ext_mod3_ff;
    reg ext_div3_ff;
    reg [2:0] lf_cnt_ff;
    reg [3:0] settle_ff;
    reg hf_osc_ready_flag_ff;
    reg core_sync_ff;

    wire sel_hit;
    wire ctrl_hit;
    wire trim_hit;
    wire hf_rise;
    wire ext_rise;
    wire lf_rise;
    wire wake_any;
    wire hf_wave;
    wire ext_wave;
    wire lf_wave;
    wire core_from_hf;
    wire core_switched;
    reg hf_scaled;
    reg lf_scaled;
    wire [7:0] core_src;
    wire [7:0] usb_src;
    wire [7:0] sel_value;
    wire [7:0] ctrl_value;
    wire [7:0] trim_value;
    wire [7:0] sel_reset;
    wire [7:0] ctrl_reset;

    // Full reset words, sliced per field except the HF post divide
    assign sel_reset = `CSEL_CLK_SELECT_RESET;
    assign ctrl_reset = `CSEL_HF_CTRL_RESET;

    assign sel_hit = (sfr_addr == `CSEL_ADDR_CLK_SELECT);
    assign ctrl_hit = (sfr_addr == `CSEL_ADDR_HF_CTRL);
    assign trim_hit = (sfr_addr == `CSEL_ADDR_HF_TRIM);

    always @(posedge clk) begin
        if (!reset_n) begin
            hf_osc_trim_ff <= factory_trim;
        end else if (sfr_wr && trim_hit) begin
            hf_osc_trim_ff <= sfr_wdata[`CSEL_TRIM_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            core_clock_source_sel_ff <= sel_reset[`CSEL_SEL_CORE_MSB:`CSEL_SEL_CORE_LSB];
            usb_clk_source_sel_ff <= sel_reset[`CSEL_SEL_USB_MSB:`CSEL_SEL_USB_LSB];
            pin_clock_sync_sel_ff <= sel_reset[`CSEL_SEL_PIN_SYNC];
        end else if (sfr_wr && sel_hit) begin
            core_clock_source_sel_ff <= sfr_wdata[`CSEL_SEL_CORE_MSB:`CSEL_SEL_CORE_LSB];
            usb_clk_source_sel_ff <= sfr_wdata[`CSEL_SEL_USB_MSB:`CSEL_SEL_USB_LSB];
            pin_clock_sync_sel_ff <= sfr_wdata[`CSEL_SEL_PIN_SYNC];
        end
    end

    assign wake_any = wake_port0_match | wake_port1_match | wake_timer3_ovf | wake_usb_resume;

    always @* begin
        nxt_suspend = hf_osc_suspend_ff;
        if (wake_any) begin
            nxt_suspend = 1'b0;
        end
        if (sfr_wr && ctrl_hit && sfr_wdata[`CSEL_CTRL_SUSPEND]) begin
            nxt_suspend = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            hf_osc_enable_ff <= ctrl_reset[`CSEL_CTRL_ENABLE];
            hf_osc_suspend_ff <= ctrl_reset[`CSEL_CTRL_SUSPEND];
            hf_osc_post_divide_ff <= `CSEL_DIV_BY8;
        end else begin
            hf_osc_suspend_ff <= nxt_suspend;
            if (sfr_wr && ctrl_hit) begin
                hf_osc_enable_ff <= sfr_wdata[`CSEL_CTRL_ENABLE];
                hf_osc_post_divide_ff <= sfr_wdata[`CSEL_CTRL_DIV_MSB:`CSEL_CTRL_DIV_LSB];
            end
        end
    end

    assign hf_osc_run = hf_osc_enable_ff & ~hf_osc_suspend_ff;

    // Oscillator pins cross into clk domain
    always @(posedge clk) begin
        if (!reset_n) begin
            src_meta_ff <= 3'h0;
            src_sync_ff <= 3'h0;
            src_prev_ff <= 3'h0;
        end else begin
            src_meta_ff <= {lf_osc_clk, ext_osc_clk, hf_osc_clk};
            src_sync_ff <= src_meta_ff;
            src_prev_ff <= src_sync_ff;
        end
    end

    assign hf_wave = src_sync_ff[0] & hf_osc_run;
    assign ext_wave = src_sync_ff[1];
    assign lf_wave = src_sync_ff[2];
    assign hf_rise = hf_osc_run & src_sync_ff[0] & ~src_prev_ff[0];
    assign ext_rise = src_sync_ff[1] & ~src_prev_ff[1];
    assign lf_rise = src_sync_ff[2] & ~src_prev_ff[2];

    // Divider chains count source edges
    always @(posedge clk) begin
        if (!reset_n) begin
            hf_cnt_ff <= 5'h00;
            ext_cnt_ff <= 2'h0;
            ext_mod3_ff <= 2'h0;
            ext_div3_ff <= 1'b0;
            lf_cnt_ff <= 3'h0;
        end else begin
            if (hf_rise) begin
                hf_cnt_ff <= hf_cnt_ff + 5'h01;
            end
            if (ext_rise) begin
                ext_cnt_ff <= ext_cnt_ff + 2'h1;
                ext_mod3_ff <= (ext_mod3_ff == 2'h2) ? 2'h0 : ext_mod3_ff + 2'h1;
                ext_div3_ff <= (ext_mod3_ff == 2'h2);
            end
            if (lf_rise) begin
                lf_cnt_ff <= lf_cnt_ff + 3'h1;
            end
        end
    end

    always @* begin
        case (hf_osc_post_divide_ff)
            `CSEL_DIV_BY8: hf_scaled = hf_cnt_ff[4];
            `CSEL_DIV_BY4: hf_scaled = hf_cnt_ff[3];
            `CSEL_DIV_BY2: hf_scaled = hf_cnt_ff[2];
            default: hf_scaled = hf_cnt_ff[1];
        endcase
    end

    always @* begin
        case (lf_osc_post_divide)
            `CSEL_DIV_BY8: lf_scaled = lf_cnt_ff[2];
            `CSEL_DIV_BY4: lf_scaled = lf_cnt_ff[1];
            `CSEL_DIV_BY2: lf_scaled = lf_cnt_ff[0];
            default: lf_scaled = lf_wave;
        endcase
    end

    assign core_src = {3'h0, lf_scaled, hf_wave, hf_cnt_ff[0], ext_wave, hf_scaled};

    assign usb_src = {1'b0, lf_wave, ext_cnt_ff[1], ext_div3_ff, ext_cnt_ff[0], ext_wave,
        hf_cnt_ff[2], hf_wave};

    csel_clk_switch u_core_switch (
        .clk(clk),
        .reset_n(reset_n),
        .sel(core_clock_source_sel_ff),
        .src(core_src),
        .clk_out_ff(core_switched)
    );

    csel_clk_switch u_usb_switch (
        .clk(clk),
        .reset_n(reset_n),
        .sel(usb_clk_source_sel_ff),
        .src(usb_src),
        .clk_out_ff(usb_clock)
    );

    assign core_from_hf = (core_clock_source_sel_ff == `CSEL_CORE_HF_SCALED) ||
        (core_clock_source_sel_ff == `CSEL_CORE_HF_DIV2) ||
        (core_clock_source_sel_ff == `CSEL_CORE_HF);

    assign core_clock_run = ~(hf_osc_suspend_ff & core_from_hf);
    assign core_clock = core_switched & core_clock_run;

    always @(posedge clk) begin
        if (!reset_n) begin
            core_sync_ff <= 1'b0;
            pin_clock_ff <= 1'b0;
        end else begin
            core_sync_ff <= core_clock;
            pin_clock_ff <= pin_clock_sync_sel_ff ? core_sync_ff : core_clock;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            settle_ff <= 4'h0;
            hf_osc_ready_flag_ff <= 1'b1;
        end else if (!hf_osc_run) begin
            settle_ff <= 4'h0;
            hf_osc_ready_flag_ff <= 1'b0;
        end else if (settle_ff < `CSEL_HF_SETTLE_CYC) begin
            settle_ff <= settle_ff + 4'h1;
            hf_osc_ready_flag_ff <= 1'b0;
        end else begin
            hf_osc_ready_flag_ff <= 1'b1;
        end
    end

    assign sel_value = {1'b0, usb_clk_source_sel_ff, pin_clock_sync_sel_ff,
        core_clock_source_sel_ff};
    assign ctrl_value = {hf_osc_enable_ff, hf_osc_ready_flag_ff, hf_osc_suspend_ff, 3'h0,
        hf_osc_post_divide_ff};
    assign trim_value = {1'b0, hf_osc_trim_ff};

    always @(posedge clk) begin
        if (!reset_n) begin
            sfr_rdata_ff <= `CSEL_RDATA_RESET;
        end else if (sfr_rd) begin
            if (sel_hit) begin
                sfr_rdata_ff <= sel_value;
            end else if (ctrl_hit) begin
                sfr_rdata_ff <= ctrl_value;
            end else if (trim_hit) begin
                sfr_rdata_ff <= trim_value;
            end else begin
                sfr_rdata_ff <= `CSEL_RDATA_RESET;
            end
        end
    end

endmodule // csel_top

`default_nettype wire

//--- csel_defines.vh
// Register offsets, field positions, reset values and timing counts for the clock select block
`ifndef CSEL_DEFINES_VH
`define CSEL_DEFINES_VH

`define CSEL_ADDR_CLK_SELECT 8'hA9
`define CSEL_ADDR_HF_CTRL 8'hB2
`define CSEL_ADDR_HF_TRIM 8'hB3

`define CSEL_CLK_SELECT_RESET 8'h00
`define CSEL_HF_CTRL_RESET 8'hC0
`define CSEL_RDATA_RESET 8'h00

`define CSEL_SEL_CORE_LSB 0
`define CSEL_SEL_CORE_MSB 2
`define CSEL_SEL_PIN_SYNC 3
`define CSEL_SEL_USB_LSB 4
`define CSEL_SEL_USB_MSB 6

`define CSEL_CTRL_ENABLE 7
`define CSEL_CTRL_READY 6
`define CSEL_CTRL_SUSPEND 5
`define CSEL_CTRL_DIV_LSB 0
`define CSEL_CTRL_DIV_MSB 1
`define CSEL_TRIM_MSB 6

`define CSEL_CORE_HF_SCALED 3'h0
`define CSEL_CORE_EXT 3'h1
`define CSEL_CORE_HF_DIV2 3'h2
`define CSEL_CORE_HF 3'h3
`define CSEL_CORE_LF_SCALED 3'h4

`define CSEL_USB_HF 3'h0
`define CSEL_USB_HF_DIV8 3'h1
`define CSEL_USB_EXT 3'h2
`define CSEL_USB_EXT_DIV2 3'h3
`define CSEL_USB_EXT_DIV3 3'h4
`define CSEL_USB_EXT_DIV4 3'h5
`define CSEL_USB_LF 3'h6

`define CSEL_DIV_BY8 2'h0
`define CSEL_DIV_BY4 2'h1
`define CSEL_DIV_BY2 2'h2
`define CSEL_DIV_BY1 2'h3

`define CSEL_CLK_PERIOD_NS 40
`define CSEL_HF_SETTLE_NS 200
`define CSEL_HF_SETTLE_CYC ((`CSEL_HF_SETTLE_NS + `CSEL_CLK_PERIOD_NS - 1) / `CSEL_CLK_PERIOD_NS)

`endif

//--- csel_clk_switch.v
// Glitch-free switch between eight clock waveforms
`default_nettype none

module csel_clk_switch (
    input wire clk,
    input wire reset_n,
    input wire [2:0] sel,
    input wire [7:0] src,
    output reg clk_out_ff
);

    localparam ST_FOLLOW = 1'b0;
    localparam ST_WAIT_NEW = 1'b1;

    reg state_ff;
    reg nxt_state;
    reg [2:0] cur_ff;
    reg [2:0] nxt_cur;
    reg nxt_clk_out;

    always @* begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_clk_out = 1'b0;
        case (state_ff)
            ST_FOLLOW: begin
                if (sel != cur_ff && !src[cur_ff]) begin
                    nxt_cur = sel;
                    nxt_state = ST_WAIT_NEW;
                end else begin
                    nxt_clk_out = src[cur_ff];
                end
            end
            default: begin
                nxt_cur = sel;
                if (!src[sel]) begin
                    nxt_state = ST_FOLLOW;
                end
            end
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= ST_FOLLOW;
            cur_ff <= 3'h0;
            clk_out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            clk_out_ff <= nxt_clk_out;
        end
    end

endmodule // csel_clk_switch

`default_nettype wire

//--- csel_top_chk.sv
// Port-level assertions for the clock select block
`default_nettype none
`include "csel_defines.vh"

module csel_top_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata_ff,
    input wire logic [6:0] factory_trim,
    input wire logic wake_port0_match,
    input wire logic wake_port1_match,
    input wire logic wake_timer3_ovf,
    input wire logic wake_usb_resume,
    input wire logic [6:0] hf_osc_trim_ff,
    input wire logic hf_osc_run,
    input wire logic core_clock_run,
    input wire logic core_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic any_wake;
    logic susp_wr;
    assign any_wake = wake_port0_match | wake_port1_match | wake_timer3_ovf | wake_usb_resume;
    assign susp_wr = sfr_wr && sfr_addr == `CSEL_ADDR_HF_CTRL && sfr_wdata[`CSEL_CTRL_SUSPEND];
    sequence s_susp_wr;
        susp_wr;
    endsequence
    sequence s_no_wake;
        !any_wake [*4];
    endsequence
    property p_sel_b7;
        sfr_rd && sfr_addr == `CSEL_ADDR_CLK_SELECT |=> !sfr_rdata_ff[7];
    endproperty
    property p_trim_rd;
        sfr_rd && sfr_addr == `CSEL_ADDR_HF_TRIM |=> sfr_rdata_ff == {1'b0, $past(hf_osc_trim_ff)};
    endproperty
    property p_trim_rst;
        disable iff (1'b0) !reset_n |=> hf_osc_trim_ff == $past(factory_trim);
    endproperty
    property p_trim_wr;
        sfr_wr && sfr_addr == `CSEL_ADDR_HF_TRIM |=> hf_osc_trim_ff == $past(sfr_wdata[6:0]);
    endproperty
    property p_susp_hold;
        s_susp_wr ##1 s_no_wake |-> !hf_osc_run && !$past(hf_osc_run, 3);
    endproperty
    property p_wake;
        any_wake && !susp_wr |=> core_clock_run;
    endproperty
    property p_gate;
        !core_clock_run |-> !core_clock;
    endproperty
    property p_rst_run;
        disable iff (1'b0) !reset_n |=> core_clock_run && hf_osc_run;
    endproperty
    a_sel_b7: assert property (p_sel_b7) else $error("select bit 7 read as one");
    a_trim_rd: assert property (p_trim_rd) else $error("trim read data wrong");
    a_trim_rst: assert property (p_trim_rst) else $error("trim not loaded in reset");
    a_trim_wr: assert property (p_trim_wr) else $error("trim write not taken");
    a_susp_hold: assert property (p_susp_hold) else $error("suspend left early");
    a_wake: assert property (p_wake) else $error("wake did not restart clock");
    a_gate: assert property (p_gate) else $error("core clock not gated");
    a_rst_run: assert property (p_rst_run) else $error("oscillator idle in reset");
endmodule // csel_top_chk

bind csel_top csel_top_chk u_chk (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_ff(sfr_rdata_ff),
    .factory_trim(factory_trim), .wake_port0_match(wake_port0_match),
    .wake_port1_match(wake_port1_match), .wake_timer3_ovf(wake_timer3_ovf),
    .wake_usb_resume(wake_usb_resume), .hf_osc_trim_ff(hf_osc_trim_ff),
    .hf_osc_run(hf_osc_run), .core_clock_run(core_clock_run), .core_clock(core_clock));
`default_nettype wire

//--- csel_top_tb_top.sv
// Self-checking bench for the clock select block
`default_nettype none
`include "csel_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t ns: unexpected result", $time); end end

module csel_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] FACT_TRIM = 7'h2A;
    logic clk, reset_n, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, q;
    logic [3:0] wake;
    logic [1:0] lf_div;
    wire [7:0] sfr_rdata_ff;
    wire [6:0] hf_osc_trim_ff;
    wire hf_osc_run, core_clock_run, core_clock, usb_clock, pin_clock_ff;
    int fails = 0;
    int n_compared = 0;
    int osc_cnt = 0;
    wire hf_osc_clk = (osc_cnt % 8) >= 4;
    wire ext_osc_clk = (osc_cnt % 10) >= 5;
    wire lf_osc_clk = (osc_cnt % 12) >= 6;

    csel_top u_dut (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_ff(sfr_rdata_ff), .factory_trim(FACT_TRIM),
        .hf_osc_clk(hf_osc_clk), .ext_osc_clk(ext_osc_clk), .lf_osc_clk(lf_osc_clk),
        .lf_osc_post_divide(lf_div), .wake_port0_match(wake[0]), .wake_port1_match(wake[1]),
        .wake_timer3_ovf(wake[2]), .wake_usb_resume(wake[3]), .hf_osc_trim_ff(hf_osc_trim_ff),
        .hf_osc_run(hf_osc_run), .core_clock_run(core_clock_run), .core_clock(core_clock),
        .usb_clock(usb_clock), .pin_clock_ff(pin_clock_ff));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) osc_cnt <= osc_cnt + 1;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        q = sfr_rdata_ff;
    endtask

    // Period in clk cycles between rising edges, 0 if still
    task automatic measure(input logic use_usb, input int exp);
        int t0;
        int per;
        logic prev;
        logic cur;
        t0 = -1;
        per = 0;
        prev = 1'b1;
        repeat (600) @(negedge clk);
        for (int n = 0; n < 600; n++) begin
            @(negedge clk);
            cur = use_usb ? usb_clock : core_clock;
            if (cur === 1'b1 && prev === 1'b0) begin
                if (t0 >= 0 && per == 0) per = n - t0;
                t0 = n;
            end
            prev = cur;
        end
        `CHK(per, exp)
    endtask

    task automatic t_reset;
        rd(`CSEL_ADDR_CLK_SELECT);
        `CHK(q, 8'h00)
        rd(`CSEL_ADDR_HF_TRIM);
        `CHK(q, {1'b0, FACT_TRIM})
        rd(`CSEL_ADDR_HF_CTRL);
        `CHK(q[1:0], 2'h0)
        `CHK(q[6], 1'b1)
        measure(1'b0, 256);
    endtask

    task automatic t_regs;
        wr(`CSEL_ADDR_CLK_SELECT, 8'hFF);
        rd(`CSEL_ADDR_CLK_SELECT);
        `CHK(q, 8'h7F)
        wr(`CSEL_ADDR_HF_TRIM, 8'hFF);
        rd(`CSEL_ADDR_HF_TRIM);
        `CHK(q, 8'h7F)
        `CHK(hf_osc_trim_ff, 7'h7F)
        wr(`CSEL_ADDR_HF_TRIM, 8'h00);
        `CHK(hf_osc_trim_ff, 7'h00)
        rd(8'hA8);
        `CHK(q, 8'h00)
    endtask

    task automatic t_core;
        int per_tab[6] = '{32, 10, 16, 8, 12, 0};
        wr(`CSEL_ADDR_CLK_SELECT, 8'h00);
        for (int d = 0; d < 4; d++) begin
            wr(`CSEL_ADDR_HF_CTRL, 8'h80 | d[7:0]);
            measure(1'b0, 256 >> d);
        end
        for (int c = 0; c < 6; c++) begin
            wr(`CSEL_ADDR_CLK_SELECT, c[7:0]);
            measure(1'b0, per_tab[c]);
        end
        lf_div = 2'h0;
        wr(`CSEL_ADDR_CLK_SELECT, 8'h04);
        measure(1'b0, 96);
        lf_div = 2'h3;
    endtask

    task automatic t_usb;
        int per_tab[8] = '{8, 64, 10, 20, 30, 40, 12, 0};
        for (int u = 0; u < 8; u++) begin
            wr(`CSEL_ADDR_CLK_SELECT, {1'b0, u[2:0], 4'h3});
            measure(1'b1, per_tab[u]);
        end
    endtask

    task automatic t_pin;
        logic d0, d1, d2;
        for (int b = 0; b < 2; b++) begin
            wr(`CSEL_ADDR_CLK_SELECT, {4'h0, b[0], 3'h3});
            repeat (50) @(negedge clk);
            for (int i = 0; i < 40; i++) begin
                @(negedge clk);
                d2 = d1;
                d1 = d0;
                d0 = core_clock;
                if (i >= 2) `CHK(pin_clock_ff, b ? d2 : d1)
            end
        end
    endtask

    task automatic t_susp;
        wr(`CSEL_ADDR_CLK_SELECT, 8'h00);
        for (int w = 0; w < 4; w++) begin
            wr(`CSEL_ADDR_HF_CTRL, 8'hA0);
            `CHK(hf_osc_run, 1'b0)
            repeat (5) @(negedge clk);
            `CHK(core_clock, 1'b0)
            wake = 4'h1 << w;
            @(negedge clk);
            wake = 4'h0;
            `CHK(core_clock_run, 1'b1)
            `CHK(hf_osc_run, 1'b1)
        end
        wr(`CSEL_ADDR_CLK_SELECT, 8'h01);
        wr(`CSEL_ADDR_HF_CTRL, 8'hA0);
        `CHK(core_clock_run, 1'b1)
        wake = 4'h4;
        @(negedge clk);
        wake = 4'h0;
        repeat (12) @(negedge clk);
        rd(`CSEL_ADDR_HF_CTRL);
        `CHK(q, 8'hC0)
    endtask

    task automatic end_of_test;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(40 * 60000);
        fails++;
        end_of_test();
    end

    initial begin
        reset_n = 1'b0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        wake = 4'h0;
        lf_div = 2'h3;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (10) @(negedge clk);
        t_reset();
        t_regs();
        t_core();
        t_usb();
        t_pin();
        t_susp();
        end_of_test();
    end
endmodule // csel_top_tb_top
`default_nettype wire
